// ==== verilog/src_sync_host.sv ====
// Host end: starts a conversion, frames the read, supplies the serial clock and gathers the word.
// Assumes link inputs are synchronous to clock_in and the device is set to the mode in ctrl.
`timescale 1ns/1ps
module src_sync_host #(
   parameter int SCLK_HALF = src_sync_pkg::SCLK_HALF_DEFAULT
) (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire src_sync_pkg::addr_t reg_addr_in,
   input wire src_sync_pkg::data_t reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output src_sync_pkg::data_t reg_rdata_out,
   src_sync_if.host link
);
   import src_sync_pkg::*;

   typedef enum logic [2:0] {H_IDLE, H_TRIG, H_SETUP, H_FRAME} host_state_t;

   if (SCLK_HALF < 1 || SCLK_HALF > 255) begin : g_check
      $error("SCLK_HALF must lie between 1 and 255");
   end

   // -------------------------------------------------------------------------
   // Registers.
   // -------------------------------------------------------------------------
   byte_t mode_reg; // Copy of the device output control value.
   logic zone2_reg; // Transfers happen in zone 2.
   logic pin_rst_reg; // Hold the device reset pin active.
   logic done_reg; // Word captured, sticky.
   logic refused_reg; // Last start refused, sticky.
   byte_t count_reg; // Strobe rising edges seen in the last frame.
   word_t data_reg; // Last captured word.
   host_state_t state_reg;

   strobe_src_t src;
   logic ddr;
   logic [2:0] nlanes;
   assign src = strobe_src_t'(mode_reg[SRC_SEL_LSB +: 2]);
   assign ddr = mode_reg[RATE_BIT];
   assign nlanes = lanes_of(mode_reg[WIDTH_LSB +: 2]);

   logic ctrl_wr;
   logic start_ok;
   logic rd_stat;
   logic frame_end;
   assign ctrl_wr = reg_wr_in && (reg_addr_in == HOST_CTRL_ADDR);
   // Oscillator strobes are refused for zone 2 transfers.
   assign start_ok = !(reg_wdata_in[CTRL_ZONE2_BIT] &&
                       (reg_wdata_in[SRC_SEL_LSB +: 2] != 2'(STROBE_HOST))); // R13
   assign rd_stat = reg_rd_in && (reg_addr_in == HOST_STAT_ADDR);

   // Control writes are ignored while a frame runs.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mode_reg <= 8'h00;
         zone2_reg <= 1'b0;
         pin_rst_reg <= 1'b0;
      end else if (ce_in && reg_wr_in) begin
         if (ctrl_wr && state_reg == H_IDLE) begin
            mode_reg <= reg_wdata_in[7:0];
            zone2_reg <= reg_wdata_in[CTRL_ZONE2_BIT];
         end else if (reg_addr_in == HOST_PIN_ADDR) begin
            pin_rst_reg <= reg_wdata_in[0];
         end
      end
   end

   // Sticky flags: a set in the same cycle as a status read wins.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else if (ce_in) begin
         done_reg <= frame_end || (done_reg && !rd_stat);
         refused_reg <= (ctrl_wr && reg_wdata_in[CTRL_START_BIT] && state_reg == H_IDLE && !start_ok) ||
                        (refused_reg && !rd_stat);
      end
   end

   // Read data stand for one cycle after the strobe and are zero otherwise.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (ce_in) begin
         if (!reg_rd_in) begin
            reg_rdata_out <= 32'h0000_0000;
         end else if (reg_addr_in == HOST_CTRL_ADDR) begin
            reg_rdata_out <= {22'h00_0000, zone2_reg, 1'b0, mode_reg};
         end else if (reg_addr_in == HOST_STAT_ADDR) begin
            reg_rdata_out <= {8'h00, optimal_strobes(mode_reg[WIDTH_LSB +: 2], ddr), count_reg, // R11
                              5'h00, refused_reg, done_reg, state_reg != H_IDLE};
         end else if (reg_addr_in == HOST_DATA_ADDR) begin
            reg_rdata_out <= {10'h000, data_reg};
         end else if (reg_addr_in == HOST_PIN_ADDR) begin
            reg_rdata_out <= {31'h0000_0000, pin_rst_reg};
         end else begin
            reg_rdata_out <= 32'h0000_0000;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Capture on the device strobe.
   // -------------------------------------------------------------------------
   logic strobe_q; // Strobe level one cycle ago.
   logic seen_rise_reg; // First rising strobe edge of the frame seen.
   count_t left_reg; // Bits still expected.
   word_t rx_reg; // Bits gathered so far.
   logic rise;
   logic capture;
   logic [2:0] take;
   word_t rx_next;

   assign rise = link.source_clock_out && !strobe_q;
   // Capture follows the device strobe, so the host clock's own timing never matters.
   assign capture = (state_reg == H_FRAME) &&
                    (rise || (ddr && !link.source_clock_out && strobe_q && seen_rise_reg)); // R18
   assign take = (left_reg < 5'(nlanes)) ? left_reg[2:0] : nlanes;
   assign frame_end = (state_reg == H_FRAME) && (left_reg == 5'h00);

   // Lane 0 holds the earliest bit; padding beyond the word is dropped.
   always_comb begin
      rx_next = rx_reg;
      for (int i = 0; i < LANES; i++) begin
         if (3'(i) < take) begin
            rx_next = {rx_next[WORD_BITS-2:0], link.out_lane[i]};
         end
      end
   end

   // -------------------------------------------------------------------------
   // Frame sequencer and pin drivers.
   // -------------------------------------------------------------------------
   logic trig_reg;
   logic cs_b_reg;
   logic sclk_reg;
   byte_t half_cnt_reg;

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg <= H_IDLE;
         trig_reg <= 1'b0;
         cs_b_reg <= 1'b1;
         sclk_reg <= 1'b0;
         half_cnt_reg <= 8'h00;
         strobe_q <= 1'b0;
         seen_rise_reg <= 1'b0;
         left_reg <= 5'h00;
         rx_reg <= '0;
         count_reg <= 8'h00;
         data_reg <= '0;
      end else if (ce_in) begin
         strobe_q <= link.source_clock_out;
         unique case (state_reg)
            H_IDLE: begin
               if (ctrl_wr && reg_wdata_in[CTRL_START_BIT] && start_ok) begin
                  state_reg <= H_TRIG;
                  trig_reg <= 1'b1; // R14
               end
            end
            H_TRIG: begin
               trig_reg <= 1'b0;
               cs_b_reg <= 1'b0;
               state_reg <= H_SETUP;
            end
            H_SETUP: begin
               left_reg <= 5'(WORD_BITS);
               seen_rise_reg <= 1'b0;
               count_reg <= 8'h00;
               half_cnt_reg <= 8'h00;
               state_reg <= H_FRAME;
            end
            H_FRAME: begin
               if (frame_end) begin
                  cs_b_reg <= 1'b1;
                  sclk_reg <= 1'b0;
                  data_reg <= rx_reg;
                  state_reg <= H_IDLE;
               end else begin
                  // The serial clock runs only when it is the strobe source.
                  if (src == STROBE_HOST) begin
                     if (half_cnt_reg == 8'(SCLK_HALF - 1)) begin
                        half_cnt_reg <= 8'h00;
                        sclk_reg <= ~sclk_reg;
                     end else begin
                        half_cnt_reg <= half_cnt_reg + 8'h01;
                     end
                  end
                  if (rise) begin
                     seen_rise_reg <= 1'b1;
                     count_reg <= count_reg + 8'h01; // R11
                  end
                  if (capture) begin
                     rx_reg <= rx_next;
                     left_reg <= left_reg - 5'(take);
                  end
               end
            end
         endcase
      end
   end

   assign link.conversion_trigger = trig_reg;
   assign link.cs_b = cs_b_reg;
   assign link.host_clk = sclk_reg;
   assign link.dev_reset_b = ~pin_rst_reg; // R14 R15

endmodule : src_sync_host

// ==== verilog/src_sync_pkg.sv ====
// Constants, types and helpers shared by both ends of the output link.
// Assumes one 250 MHz clock at both ends, with link pins sampled on it.
// Functional notes
// R1 - Device drives strobe pin as data clock.
// R2 - Strobe from host clock, oscillator, /2, /4.
// R3 - Strobe source select is control bits 7:6.
// R4 - Lane width field defaults single; dual, quad.
// R5 - Width 10b launches two bits per edge.
// R6 - Width 11b launches four bits per edge.
// R7 - Rate bit 4 defaults SDR; set means DDR.
// R8 - SDR launches only on strobe rising edges.
// R9 - DDR launches every edge from first rising.
// R10 - All 24 source, width, rate combinations accepted.
// R11 - Host expects 10, 5 or 3 strobes.
// R12 - Any input protocol value works meanwhile.
// R13 - Oscillator strobes only in zone 1.
// R14 - Minimal hookup: trigger on select, reset idle.
// R15 - Reset pin resets device asynchronously.
// R16 - Output control register sits at 00Ch.
// R17 - Output word is 22 bits, MSB first.
// R18 - Host captures on device strobe edges.
package src_sync_pkg;

   // -------------------------------------------------------------------------
   // Timing.
   // -------------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000; // System clock period.
   localparam int INT_OSC_PERIOD_PS = 8000; // Internal oscillator period.
   // Half oscillator period in whole system cycles, rounded up.
   localparam int INT_OSC_HALF_CYC = (INT_OSC_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SCLK_HALF_DEFAULT = 2; // Host clock half period in cycles.

   // -------------------------------------------------------------------------
   // Word and bus shapes.
   // -------------------------------------------------------------------------
   localparam int WORD_BITS = 22; // Output word length.
   localparam int LANES = 4; // Number of output lanes.
   typedef logic [WORD_BITS-1:0] word_t;
   typedef logic [4:0] count_t; // Holds up to the word length.
   typedef logic [11:0] addr_t;
   typedef logic [7:0] byte_t;
   typedef logic [31:0] data_t;

   // -------------------------------------------------------------------------
   // Device register map and fields.
   // -------------------------------------------------------------------------
   localparam addr_t OPC_ADDR = 12'h00c; // Output protocol control.
   localparam addr_t IPC_ADDR = 12'h008; // Input protocol control.
   localparam addr_t DEV_STAT_ADDR = 12'h040; // Device state, read only.
   localparam byte_t OPC_RESET = 8'h00;
   localparam byte_t IPC_RESET = 8'h00;
   localparam int SRC_SEL_LSB = 6;
   localparam int RATE_BIT = 4;
   localparam int WIDTH_LSB = 2;
   localparam int MODE_LSB = 0;
   localparam logic [1:0] MODE_SRC_SYNC = 2'h3;
   localparam logic [1:0] WIDTH_DUAL = 2'h2;
   localparam logic [1:0] WIDTH_QUAD = 2'h3;
   typedef enum logic [1:0] {STROBE_HOST, STROBE_INT, STROBE_DIV2, STROBE_DIV4} strobe_src_t;

   // -------------------------------------------------------------------------
   // Host register map and fields.
   // -------------------------------------------------------------------------
   localparam addr_t HOST_CTRL_ADDR = 12'h000;
   localparam addr_t HOST_STAT_ADDR = 12'h004;
   localparam addr_t HOST_DATA_ADDR = 12'h008;
   localparam addr_t HOST_PIN_ADDR = 12'h00c;
   localparam int CTRL_START_BIT = 8;
   localparam int CTRL_ZONE2_BIT = 9;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_REFUSED_BIT = 2;

   // Lanes in use for a width code; codes 00b and 01b both mean one lane.
   function automatic logic [2:0] lanes_of(input logic [1:0] w);
      lanes_of = (w == WIDTH_QUAD) ? 3'h4 : (w == WIDTH_DUAL) ? 3'h2 : 3'h1; // R4 R5 R6
   endfunction : lanes_of

   // Strobe count of an optimal read for a width and rate.
   function automatic byte_t optimal_strobes(input logic [1:0] w, input logic ddr);
      if (w == WIDTH_QUAD && ddr) optimal_strobes = 8'h03; // R11
      else if ((w == WIDTH_QUAD) || (w == WIDTH_DUAL && ddr)) optimal_strobes = 8'h05;
      else optimal_strobes = 8'h0a;
   endfunction : optimal_strobes

   // Cycles per strobe half period for the oscillator-based sources.
   function automatic logic [2:0] half_period(input strobe_src_t s);
      case (s)
         STROBE_DIV2: half_period = 3'(2 * INT_OSC_HALF_CYC);
         STROBE_DIV4: half_period = 3'(4 * INT_OSC_HALF_CYC);
         default: half_period = 3'(INT_OSC_HALF_CYC);
      endcase
   endfunction : half_period

endpackage : src_sync_pkg

// ==== verilog/src_sync_if.sv ====
// Link pins between the output serializer and its host controller.
// Assumes both ends run on one common clock; every pin here is one way.
`timescale 1ns/1ps
interface src_sync_if;
   logic conversion_trigger; // Host starts a conversion on its rising edge.
   logic cs_b; // Frame select, active low.
   logic host_clk; // Host serial clock.
   logic dev_reset_b; // Device reset pin, active low.
   logic source_clock_out; // Strobe that travels with the data.
   logic [3:0] out_lane; // Output lanes 0 to 3.

   modport device (input conversion_trigger, input cs_b, input host_clk, input dev_reset_b,
                   output source_clock_out, output out_lane);
   modport host (output conversion_trigger, output cs_b, output host_clk, output dev_reset_b,
                 input source_clock_out, input out_lane);
endinterface : src_sync_if

// ==== verilog/src_sync_device.sv ====
// Device end: holds the output control registers and shifts the result word out with its strobe.
// Assumes link inputs are synchronous to clock_in and the word is valid at the trigger edge.
`timescale 1ns/1ps
module src_sync_device (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire src_sync_pkg::word_t data_word_in,
   input wire src_sync_pkg::addr_t ctrl_addr_in,
   input wire src_sync_pkg::byte_t ctrl_wdata_in,
   input wire logic ctrl_wr_in,
   input wire logic ctrl_rd_in,
   output src_sync_pkg::byte_t ctrl_rdata_out,
   output logic frame_done_out,
   src_sync_if.device link
);
   import src_sync_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} dev_state_t;

   // -------------------------------------------------------------------------
   // Reset and configuration.
   // -------------------------------------------------------------------------
   // The pin reset joins the system reset; both act without the clock.
   logic rst_all_b;
   assign rst_all_b = rst_b_in & link.dev_reset_b; // R15

   byte_t opc_reg; // Output protocol control.
   byte_t ipc_reg; // Input protocol control; kept but does not steer the output path.
   dev_state_t state_reg; // Frame state.

   // Register writes from the plain control port.
   always_ff @(posedge clock_in or negedge rst_all_b) begin
      if (!rst_all_b) begin
         opc_reg <= OPC_RESET;
         ipc_reg <= IPC_RESET;
      end else if (ce_in && ctrl_wr_in) begin
         if (ctrl_addr_in == OPC_ADDR) begin
            opc_reg <= ctrl_wdata_in; // R16 R3 R10
         end else if (ctrl_addr_in == IPC_ADDR) begin
            ipc_reg <= ctrl_wdata_in; // R12
         end
      end
   end

   // Read data stand for one cycle after the strobe and are zero otherwise.
   always_ff @(posedge clock_in or negedge rst_all_b) begin
      if (!rst_all_b) begin
         ctrl_rdata_out <= 8'h00;
      end else if (ce_in) begin
         if (!ctrl_rd_in) begin
            ctrl_rdata_out <= 8'h00;
         end else if (ctrl_addr_in == OPC_ADDR) begin
            ctrl_rdata_out <= opc_reg;
         end else if (ctrl_addr_in == IPC_ADDR) begin
            ctrl_rdata_out <= ipc_reg;
         end else if (ctrl_addr_in == DEV_STAT_ADDR) begin
            ctrl_rdata_out <= {6'h00, state_reg};
         end else begin
            ctrl_rdata_out <= 8'h00; // Unmapped addresses read as zero.
         end
      end
   end

   // Decoded fields of the output protocol control register.
   strobe_src_t src;
   logic ddr;
   logic [2:0] nlanes;
   logic active;
   assign src = strobe_src_t'(opc_reg[SRC_SEL_LSB +: 2]); // R3
   assign ddr = opc_reg[RATE_BIT]; // R7
   assign nlanes = lanes_of(opc_reg[WIDTH_LSB +: 2]); // R4
   assign active = (opc_reg[MODE_LSB +: 2] == MODE_SRC_SYNC);

   // -------------------------------------------------------------------------
   // Link input edges and the held result word.
   // -------------------------------------------------------------------------
   logic cs_q; // Select level one cycle ago.
   logic trig_q; // Trigger level one cycle ago.
   word_t held_reg; // Word caught at the trigger edge.

   always_ff @(posedge clock_in or negedge rst_all_b) begin
      if (!rst_all_b) begin
         cs_q <= 1'b1;
         trig_q <= 1'b0;
      end else if (ce_in) begin
         cs_q <= link.cs_b;
         trig_q <= link.conversion_trigger;
      end
   end

   // The word is frozen at the trigger so a frame never sees it change midway.
   always_ff @(posedge clock_in or negedge rst_all_b) begin
      if (!rst_all_b) begin
         held_reg <= '0;
      end else if (ce_in && link.conversion_trigger && !trig_q) begin
         held_reg <= data_word_in;
      end
   end

   // -------------------------------------------------------------------------
   // Strobe generation.
   // -------------------------------------------------------------------------
   logic strobe_reg; // Strobe pin level.
   logic [2:0] div_reg; // Oscillator divider count.
   logic started_reg; // First rising edge of the frame seen.
   logic strobe_next;
   logic div_wrap;

   assign div_wrap = ({1'b0, div_reg} + 4'h1) >= {1'b0, half_period(src)};

   // The host source follows the sampled host clock; the others come from the divider.
   always_comb begin
      if (src == STROBE_HOST) begin
         strobe_next = link.host_clk; // R2
      end else begin
         strobe_next = div_wrap ? ~strobe_reg : strobe_reg; // R2
      end
   end

   logic rise;
   logic fall;
   logic launch;
   assign rise = strobe_next & ~strobe_reg;
   assign fall = ~strobe_next & strobe_reg;
   // SDR launches on rising edges only; DDR on both, once the first rise has passed.
   assign launch = (state_reg == ST_RUN) && (rise || (ddr && fall && started_reg)); // R8 R9

   // -------------------------------------------------------------------------
   // Shifter and frame control.
   // -------------------------------------------------------------------------
   word_t shift_reg; // Bits still to send, MSB at the top.
   count_t left_reg; // Bits still to send.
   logic [LANES-1:0] lane_reg; // Lane pins.
   logic [LANES-1:0] lane_next;

   // Lane 0 carries the earliest bit of each launch; unused lanes stay low.
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      assign lane_next[i] = (3'(i) < nlanes) ? shift_reg[WORD_BITS-1-i] : 1'b0; // R5 R6 R17
   end

   always_ff @(posedge clock_in or negedge rst_all_b) begin
      if (!rst_all_b) begin
         state_reg <= ST_IDLE;
         strobe_reg <= 1'b0;
         div_reg <= 3'h0;
         started_reg <= 1'b0;
         shift_reg <= '0;
         left_reg <= 5'h00;
         lane_reg <= '0;
         frame_done_out <= 1'b0;
      end else if (ce_in) begin
         frame_done_out <= 1'b0;
         if (link.cs_b) begin
            // Deselect ends any frame at once and parks the pins low.
            state_reg <= ST_IDLE;
            strobe_reg <= 1'b0;
            div_reg <= 3'h0;
            lane_reg <= '0;
         end else if (cs_q && active) begin
            // Select falling edge in source-synchronous mode starts a frame.
            state_reg <= ST_RUN;
            shift_reg <= held_reg; // R17
            left_reg <= 5'(WORD_BITS);
            started_reg <= 1'b0;
            strobe_reg <= 1'b0;
            div_reg <= 3'h0;
         end else if (state_reg == ST_RUN) begin
            if (left_reg == 5'h00) begin
               // All bits are out: strobe returns low and the lanes drop to zero.
               state_reg <= ST_DONE;
               strobe_reg <= 1'b0;
               lane_reg <= '0;
               frame_done_out <= 1'b1;
            end else begin
               strobe_reg <= strobe_next; // R1
               div_reg <= div_wrap ? 3'h0 : div_reg + 3'h1;
               if (rise) begin
                  started_reg <= 1'b1;
               end
               if (launch) begin
                  lane_reg <= lane_next; // R5 R6
                  shift_reg <= shift_reg << nlanes;
                  left_reg <= (left_reg > 5'(nlanes)) ? left_reg - 5'(nlanes) : 5'h00;
               end
            end
         end
      end
   end

   assign link.source_clock_out = strobe_reg; // R1
   assign link.out_lane = lane_reg;

endmodule : src_sync_device

// ==== test/src_sync_output_serializer_assertions.sv ====
// Checker for the link pins between the serializer and its host.
// Assumes one clock for both ends and an active low asynchronous reset.
`timescale 1ns/1ps
module src_sync_output_serializer_assertions (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic conversion_trigger,
   input wire logic cs_b,
   input wire logic host_clk,
   input wire logic dev_reset_b,
   input wire logic source_clock_out,
   input wire logic [3:0] out_lane
);
   logic strobe_reg; // Strobe one cycle ago.
   logic [7:0] rise_reg; // Rising strobe edges seen in the current frame.
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   // Counts rising strobe edges in a frame; cleared while select is idle.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         strobe_reg <= 1'b0;
         rise_reg <= 8'h00;
      end else begin
         strobe_reg <= source_clock_out;
         rise_reg <= cs_b ? 8'h00 : rise_reg + 8'(source_clock_out && !strobe_reg);
      end
   end
   AST_STROBE_PARKED: assert property (cs_b && $past(cs_b) |-> !source_clock_out && out_lane == 4'h0)
      else $error("strobe or lanes active outside a frame");
   AST_HOST_CLK_IDLE: assert property (cs_b && $past(cs_b) |-> !host_clk)
      else $error("host clock runs outside a frame");
   AST_TRIGGER_PULSE: assert property ($rose(conversion_trigger) |=> !conversion_trigger && !cs_b)
      else $error("trigger not a single cycle before select");
   AST_LANES_ON_STROBE: assert property ($changed(out_lane) |-> $changed(source_clock_out) || out_lane == 4'h0)
      else $error("lanes changed without a strobe edge");
   AST_FRAME_BOUND: assert property ($fell(cs_b) |-> ##[3:400] $rose(cs_b))
      else $error("frame did not end in time");
   AST_EDGE_COUNT: assert property ($rose(cs_b) |-> rise_reg inside {8'h16, 8'h0b, 8'h06, 8'h03})
      else $error("wrong count of rising strobe edges in frame");
   AST_RESET_PIN: assert property (!dev_reset_b |-> !source_clock_out && out_lane == 4'h0)
      else $error("outputs active while reset pin held");
   AST_STROBE_LOW_AT_END: assert property ($rose(cs_b) |-> !source_clock_out)
      else $error("strobe high when frame ends");
endmodule : src_sync_output_serializer_assertions

// ==== test/src_sync_output_serializer_bench.sv ====
// Bench for the source-synchronous link: drives both register ports, judges frames.
// Assumes the package, interface, both ends and the checker are compiled first.
`timescale 1ns/1ps
module src_sync_output_serializer_bench;
   import src_sync_pkg::*;
   logic clock_in, rst_b_in, dwr, drd, hwr, hrd, fdone;
   word_t word;
   addr_t da, ha;
   byte_t dwd, drdata;
   data_t hwd, hrdata, rd_val;
   int n_fail, checks_done, frames;
   src_sync_if link_if();
   src_sync_device i_src_sync_device (.clock_in(clock_in), .rst_b_in(rst_b_in), .ce_in(1'b1), .data_word_in(word),
      .ctrl_addr_in(da), .ctrl_wdata_in(dwd), .ctrl_wr_in(dwr), .ctrl_rd_in(drd), .ctrl_rdata_out(drdata),
      .frame_done_out(fdone), .link(link_if));
   src_sync_host i_src_sync_host (.clock_in(clock_in), .rst_b_in(rst_b_in), .ce_in(1'b1), .reg_addr_in(ha),
      .reg_wdata_in(hwd), .reg_wr_in(hwr), .reg_rd_in(hrd), .reg_rdata_out(hrdata), .link(link_if));
   src_sync_output_serializer_assertions i_src_sync_output_serializer_assertions (.clock_in(clock_in),
      .rst_b_in(rst_b_in), .conversion_trigger(link_if.conversion_trigger), .cs_b(link_if.cs_b),
      .host_clk(link_if.host_clk), .dev_reset_b(link_if.dev_reset_b),
      .source_clock_out(link_if.source_clock_out), .out_lane(link_if.out_lane));
   // Free-running 250 MHz clock.
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   // Counts frame ends.
   always_ff @(posedge clock_in) frames <= frames + fdone;
   task automatic check(input data_t seen, input data_t exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   // One register cycle on the device port (dev=1) or host port; read data into rd_val.
   task automatic bus(input bit dev, input bit wr, input addr_t a, input data_t d);
      @(posedge clock_in);
      if (dev) begin
         da <= a; dwd <= d[7:0]; dwr <= wr; drd <= !wr;
      end else begin
         ha <= a; hwd <= d; hwr <= wr; hrd <= !wr;
      end
      @(posedge clock_in);
      {dwr, drd, hwr, hrd} <= 4'h0;
      #1 rd_val = dev ? data_t'(drdata) : hrdata;
   endtask : bus
   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   // Polls the host status until done; a hang is cut short here.
   task automatic wait_done();
      int i;
      for (i = 0; i < 300; i++) begin
         bus(0, 0, HOST_STAT_ADDR, 0);
         if (rd_val[STAT_DONE_BIT] === 1'b1) break;
      end
      if (i == 300) begin
         n_fail++;
         finish_test();
      end
   endtask : wait_done
   // Sets both ends to one mode, runs a frame, compares the word.
   task automatic run_frame(input byte_t mode, input word_t w, input bit zone2);
      byte_t opt;
      opt = (mode[3:2] == 2'h3) ? (mode[4] ? 8'h03 : 8'h05) : (mode[3:2] == 2'h2 && mode[4]) ? 8'h05 : 8'h0a;
      @(posedge clock_in) word <= w;
      bus(1, 1, OPC_ADDR, data_t'(mode));
      bus(1, 0, OPC_ADDR, 0);
      check(rd_val, data_t'(mode), "output control readback");
      bus(0, 1, HOST_CTRL_ADDR, {22'h0, zone2, 1'b1, mode});
      wait_done();
      check(data_t'(rd_val[23:16]), data_t'(opt), "optimal strobe count");
      bus(0, 0, HOST_DATA_ADDR, 0);
      check(rd_val, data_t'(w), "received word");
   endtask : run_frame
   // Every source, width and rate, stepping the input control.
   task automatic test_all_modes();
      for (int s = 0; s < 4; s++)
         for (int r = 0; r < 2; r++)
            for (int w = 0; w < 4; w++) begin
               if (w == 1) continue;
               bus(1, 1, IPC_ADDR, data_t'(s));
               run_frame({2'(s), 1'b0, 1'(r), 2'(w), 2'h3}, 22'h2b5c3e ^ word_t'(s * 8 + r * 4 + w), 1'b0);
            end
      $display("all modes test done");
   endtask : test_all_modes
   // Oscillator strobe refused in zone 2, host clock accepted.
   task automatic test_zone2();
      bus(1, 1, OPC_ADDR, 32'h43);
      bus(0, 1, HOST_CTRL_ADDR, 32'h343);
      repeat (20) @(posedge clock_in);
      bus(0, 0, HOST_STAT_ADDR, 0);
      check(data_t'(link_if.cs_b), 32'h1, "select idle when refused");
      check(data_t'(rd_val[2:0]), 32'h4, "refused flag");
      run_frame(8'h03, 22'h3fffff, 1'b1);
      check(data_t'(frames), 32'h19, "frame ends");
      $display("zone test done");
   endtask : test_zone2
   // Reset defaults, then the reset pin clears a written control.
   task automatic test_reset_pin();
      bus(1, 0, OPC_ADDR, 0);
      check(rd_val, 32'h0, "control reset value");
      bus(1, 1, OPC_ADDR, 32'h1f);
      bus(0, 1, HOST_PIN_ADDR, 32'h1);
      bus(0, 1, HOST_PIN_ADDR, 32'h0);
      bus(1, 0, OPC_ADDR, 0);
      check(rd_val, 32'h0, "control after reset pin");
      $display("reset pin test done");
   endtask : test_reset_pin
   // Main sequence: reset for 12 cycles, then the scenarios.
   initial begin
      {dwr, drd, hwr, hrd} = 4'h0;
      da = '0; ha = '0; dwd = '0; hwd = '0; word = '0;
      n_fail = 0;
      checks_done = 0;
      rst_b_in = 1'b0;
      repeat (12) @(posedge clock_in);
      rst_b_in <= 1'b1;
      test_reset_pin();
      test_all_modes();
      test_zone2();
      finish_test();
   end
endmodule : src_sync_output_serializer_bench
